// ==== shared/reset_seq_defs.svh ====
// constants of the reset output and soft reset sequencer
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

`define CLK_PERIOD_NS 10
`define RF_TIME_NS 10000
`define LONG_DELAY_NS 10000000
`define SHORT_DELAY_NS 2000000
`define RF_CYC ((`RF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_CYC ((`LONG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_CYC ((`SHORT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 24

`define ADDR_CTRL 4'h0
`define ADDR_MODE 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_IRQ_STAT 4'h3
`define ADDR_IRQ_MASK 4'h4

`define CTRL_SHORT_BIT 0
`define CTRL_SOFT_KEEP_BIT 1
`define CTRL_THR_LSB 2
`define CTRL_THR_MSB 3
`define CTRL_FAILSAFE_BIT 4
`define CTRL_RST 8'h00

`define MODE_NORMAL 2'h0
`define MODE_STOP 2'h1
`define MODE_SOFT_RESET 2'h3

`define IRQ_RST_BIT 0
`define IRQ_WD_BIT 1
`define IRQ_SOFT_BIT 2
`define IRQ_MASK_RST 8'h00

`define WATCHDOG_FAIL_COUNT_MAX 2'h2

`endif

// ==== shared/reset_seq_pkg.sv ====
// types of the reset output and soft reset sequencer
package reset_seq_pkg;
    typedef enum logic [1:0] {
        S_RELEASED, S_FILTER, S_ASSERTED, S_DELAY
    } seq_t;
    typedef enum logic [2:0] {
        M_INIT, M_NORMAL, M_STOP, M_RESTART, M_FAILSAFE
    } dev_mode_t;
endpackage

// ==== hdl/pin_sync.sv ====
// three stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept a change once the last two stages agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            level <= RST_VAL;
        end else if (s2_reg == s3_reg) begin
            level <= s3_reg;
        end
    end
endmodule // pin_sync

// ==== hdl/reset_sequencer.sv ====
// reset output generation and soft reset sequencer
// Operation
// - a reset cause drives the reset output low only after the filter time.
// - the output stays low while the cause lasts and until the delay ends.
// - the delay is long by default and short when short select is set.
// - from power-up the reset output is held low until supply is valid.
// - at power-up the output is released after the long release delay.
// - a watchdog failure is a reset cause through the same sequence.
// - the undervoltage threshold is selectable and defaults after reset.
// - an accepted soft reset returns to init with all registers defaulted, then sets the soft reset event in the interrupt status.
// - with soft reset keep at 0 a soft reset pulses reset with long delay.
// - with soft reset keep at 1 a soft reset leaves the output high.
// - a soft reset is obeyed only in normal or stop mode.
// - a watchdog reset enters restart or fail-safe and counts the failure.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "reset_seq_defs.svh"
module reset_sequencer #(
    parameter int LONG_DELAY_CYC = `LONG_CYC,
    parameter int SHORT_DELAY_CYC = `SHORT_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SUPPLY_LOW,
    input wire logic WATCHDOG_FAIL_COUNT,
    output logic RESET_OUT_N,
    output logic [1:0] UV_THRESH_SEL,
    output logic SOFT_RESET_PULSE,
    output logic IRQ
);
    localparam int RF_N = `RF_CYC;
    localparam logic [`CNT_W-1:0] RF_LAST = (`CNT_W)'(RF_N - 1);
    localparam logic [`CNT_W-1:0] LONG_LAST =
        (`CNT_W)'(LONG_DELAY_CYC - 1);
    localparam logic [`CNT_W-1:0] SHORT_LAST =
        (`CNT_W)'(SHORT_DELAY_CYC - 1);

    reset_seq_pkg::seq_t state_reg;
    reset_seq_pkg::dev_mode_t mode_reg;
    logic [`CNT_W-1:0] cnt_reg;
    logic [`CNT_W-1:0] delay_last;
    logic use_long_reg;
    logic wd_cause_reg;
    logic uv_level;
    logic cause;
    logic [7:0] ctrl_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_stat_next;
    logic [7:0] irq_mask_reg;
    logic [1:0] wd_count_reg;
    logic mode_ok;
    logic soft_cmd;
    logic soft_exec;
    logic soft_assert;
    logic assert_now;
    logic release_now;
    logic supply_seen_reg;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = (a == o);
    endfunction

    function automatic logic [2:0] mode_code(
        input reset_seq_pkg::dev_mode_t m
    );
        case (m)
            reset_seq_pkg::M_INIT: mode_code = 3'h0;
            reset_seq_pkg::M_NORMAL: mode_code = 3'h1;
            reset_seq_pkg::M_STOP: mode_code = 3'h2;
            reset_seq_pkg::M_RESTART: mode_code = 3'h3;
            reset_seq_pkg::M_FAILSAFE: mode_code = 3'h4;
            default: mode_code = 3'h7;
        endcase
    endfunction

    // supply undervoltage comparator from the pin
    pin_sync #(
        .RST_VAL(1'b1)
    ) u_uv_sync (
        .clk(CLK),
        .nrst(NRST),
        .pin(SUPPLY_LOW),
        .level(uv_level)
    );

    assign cause = uv_level | wd_cause_reg;
    assign mode_ok = (mode_reg == reset_seq_pkg::M_NORMAL) ||
        (mode_reg == reset_seq_pkg::M_STOP);
    assign soft_cmd = WR && hit(ADDR, `ADDR_MODE) &&
        (WDATA[1:0] == `MODE_SOFT_RESET);
    assign soft_exec = soft_cmd && mode_ok;
    assign soft_assert = soft_exec && !ctrl_reg[`CTRL_SOFT_KEEP_BIT];
    assign delay_last = (use_long_reg || !ctrl_reg[`CTRL_SHORT_BIT]) ?
        LONG_LAST : SHORT_LAST;
    assign assert_now = soft_assert ||
        ((state_reg == reset_seq_pkg::S_FILTER) && cause &&
        (cnt_reg == RF_LAST));
    assign release_now = (state_reg == reset_seq_pkg::S_DELAY) &&
        !cause && !soft_assert && (cnt_reg == delay_last);

    // watchdog failure held as a cause until the output is low
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wd_cause_reg <= 1'b0;
        end else if (WATCHDOG_FAIL_COUNT) begin
            wd_cause_reg <= 1'b1;
        end else if (state_reg == reset_seq_pkg::S_ASSERTED) begin
            wd_cause_reg <= 1'b0;
        end
    end

    // reset output sequence
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= reset_seq_pkg::S_ASSERTED;
            cnt_reg <= '0;
            RESET_OUT_N <= 1'b0;
            use_long_reg <= 1'b1;
        end else begin
            case (state_reg)
                reset_seq_pkg::S_RELEASED: begin
                    if (soft_assert) begin
                        state_reg <= reset_seq_pkg::S_ASSERTED;
                        RESET_OUT_N <= 1'b0;
                        use_long_reg <= 1'b1;
                    end else if (cause) begin
                        state_reg <= reset_seq_pkg::S_FILTER;
                        cnt_reg <= '0;
                    end
                end
                reset_seq_pkg::S_FILTER: begin
                    if (assert_now) begin
                        state_reg <= reset_seq_pkg::S_ASSERTED;
                        RESET_OUT_N <= 1'b0;
                        use_long_reg <= soft_assert;
                    end else if (!cause) begin
                        state_reg <= reset_seq_pkg::S_RELEASED;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                reset_seq_pkg::S_ASSERTED: begin
                    if (soft_assert) begin
                        use_long_reg <= 1'b1;
                    end
                    if (!cause) begin
                        state_reg <= reset_seq_pkg::S_DELAY;
                        cnt_reg <= '0;
                    end
                end
                reset_seq_pkg::S_DELAY: begin
                    if (cause || soft_assert) begin
                        state_reg <= reset_seq_pkg::S_ASSERTED;
                        cnt_reg <= '0;
                        if (soft_assert) begin
                            use_long_reg <= 1'b1;
                        end
                    end else if (release_now) begin
                        state_reg <= reset_seq_pkg::S_RELEASED;
                        RESET_OUT_N <= 1'b1;
                        use_long_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= reset_seq_pkg::S_ASSERTED;
                    RESET_OUT_N <= 1'b0;
                end
            endcase
        end
    end

    // operating mode and watchdog failure count
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_reg <= reset_seq_pkg::M_INIT;
            wd_count_reg <= 2'h0;
        end else if (soft_exec) begin
            mode_reg <= reset_seq_pkg::M_INIT;
            wd_count_reg <= 2'h0;
        end else if (WATCHDOG_FAIL_COUNT) begin
            mode_reg <= ctrl_reg[`CTRL_FAILSAFE_BIT] ?
                reset_seq_pkg::M_FAILSAFE : reset_seq_pkg::M_RESTART;
            if (wd_count_reg != `WATCHDOG_FAIL_COUNT_MAX) begin
                wd_count_reg <= wd_count_reg + 2'h1;
            end
        end else if (release_now && (mode_reg == reset_seq_pkg::M_INIT ||
                mode_reg == reset_seq_pkg::M_RESTART)) begin
            mode_reg <= reset_seq_pkg::M_NORMAL;
        end else if (WR && hit(ADDR, `ADDR_MODE) &&
                (mode_ok || mode_reg == reset_seq_pkg::M_FAILSAFE)) begin
            if (WDATA[1:0] == `MODE_NORMAL) begin
                mode_reg <= reset_seq_pkg::M_NORMAL;
            end else if (WDATA[1:0] == `MODE_STOP) begin
                mode_reg <= reset_seq_pkg::M_STOP;
            end
        end
    end

    // control and mask registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg <= `CTRL_RST;
            irq_mask_reg <= `IRQ_MASK_RST;
        end else if (soft_exec) begin
            ctrl_reg <= `CTRL_RST;
            irq_mask_reg <= `IRQ_MASK_RST;
        end else if (WR && hit(ADDR, `ADDR_CTRL)) begin
            ctrl_reg <= WDATA;
        end else if (WR && hit(ADDR, `ADDR_IRQ_MASK)) begin
            irq_mask_reg <= WDATA;
        end
    end

    assign UV_THRESH_SEL = ctrl_reg[`CTRL_THR_MSB:`CTRL_THR_LSB];

    // sticky events, cleared by writing one, set wins
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (soft_exec) begin
            irq_stat_next = 8'h00;
        end else if (WR && hit(ADDR, `ADDR_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~WDATA;
        end
        irq_stat_next[`IRQ_RST_BIT] = irq_stat_next[`IRQ_RST_BIT] |
            assert_now;
        irq_stat_next[`IRQ_WD_BIT] = irq_stat_next[`IRQ_WD_BIT] | WATCHDOG_FAIL_COUNT;
        irq_stat_next[`IRQ_SOFT_BIT] = irq_stat_next[`IRQ_SOFT_BIT] |
            soft_exec;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_reg <= 8'h00;
            IRQ <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // internal reinit strobe for the rest of the chip
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SOFT_RESET_PULSE <= 1'b0;
        end else begin
            SOFT_RESET_PULSE <= soft_exec;
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= 8'h00;
        end else if (!RD) begin
            RDATA <= 8'h00;
        end else begin
            case (ADDR)
                `ADDR_CTRL: RDATA <= ctrl_reg;
                `ADDR_STATUS: RDATA <= {1'b0, uv_level, RESET_OUT_N,
                    mode_code(mode_reg), wd_count_reg};
                `ADDR_IRQ_STAT: RDATA <= irq_stat_reg;
                `ADDR_IRQ_MASK: RDATA <= irq_mask_reg;
                default: RDATA <= 8'h00;
            endcase
        end
    end

    // supply seen valid since reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            supply_seen_reg <= 1'b0;
        end else if (!uv_level) begin
            supply_seen_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    property p_filter;
        $fell(RESET_OUT_N) |->
            ($past(cnt_reg) == RF_LAST) || $past(soft_assert);
    endproperty
    a_filter: assert property (p_filter)
        else $error("reset asserted before filter time");

    sequence s_held_low;
        (state_reg == reset_seq_pkg::S_ASSERTED) && cause;
    endsequence
    property p_hold;
        s_held_low |=> !RESET_OUT_N;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset released while cause present");

    property p_short;
        ($rose(RESET_OUT_N) && !$past(use_long_reg) &&
            $past(ctrl_reg[`CTRL_SHORT_BIT])) |->
            $past(cnt_reg) == SHORT_LAST;
    endproperty
    a_short: assert property (p_short)
        else $error("short release delay wrong");

    property p_supply;
        RESET_OUT_N |-> supply_seen_reg;
    endproperty
    a_supply: assert property (p_supply)
        else $error("reset released before supply valid");

    property p_long;
        ($rose(RESET_OUT_N) && $past(use_long_reg)) |->
            $past(cnt_reg) == LONG_LAST;
    endproperty
    a_long: assert property (p_long)
        else $error("long release delay wrong");

    // failure latched one edge, then filter entered on the next
    property p_wd;
        (WATCHDOG_FAIL_COUNT && state_reg == reset_seq_pkg::S_RELEASED) |=>
            ##1 (state_reg == reset_seq_pkg::S_FILTER);
    endproperty
    a_wd: assert property (p_wd)
        else $error("watchdog failure not taken as cause");

    sequence s_soft;
        soft_exec;
    endsequence
    property p_defaults;
        s_soft |=> (ctrl_reg == `CTRL_RST) && (UV_THRESH_SEL == 2'h0) &&
            (mode_reg == reset_seq_pkg::M_INIT) && SOFT_RESET_PULSE;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("soft reset did not restore defaults");

    property p_soft_pulse;
        (s_soft ##0 !ctrl_reg[`CTRL_SOFT_KEEP_BIT]) |=> !RESET_OUT_N;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse)
        else $error("soft reset did not assert reset output");

    property p_soft_keep;
        (s_soft ##0 ctrl_reg[`CTRL_SOFT_KEEP_BIT] &&
            state_reg == reset_seq_pkg::S_RELEASED && !cause) |=>
            RESET_OUT_N;
    endproperty
    a_soft_keep: assert property (p_soft_keep)
        else $error("soft reset touched reset output");

    property p_ignore;
        (soft_cmd && !mode_ok) |=> !SOFT_RESET_PULSE;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("soft reset obeyed outside normal or stop");

    property p_wd_mode;
        (WATCHDOG_FAIL_COUNT && !soft_exec) |=>
            (mode_reg == reset_seq_pkg::M_RESTART ||
            mode_reg == reset_seq_pkg::M_FAILSAFE) && wd_count_reg != 2'h0;
    endproperty
    a_wd_mode: assert property (p_wd_mode)
        else $error("watchdog failure mode or count wrong");

    property p_restart;
        (state_reg == reset_seq_pkg::S_DELAY && cause) |=>
            state_reg == reset_seq_pkg::S_ASSERTED && cnt_reg == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("delay not restarted by new cause");
endmodule // reset_sequencer

// ==== bench/mcu_model.sv ====
// host side model: watches the reset line and measures its low pulses
`timescale 1ns/100ps
module mcu_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reset_in_n,
    output int low_len,
    output int falls
);
    int cnt;
    logic prev;

    // length of the last low period and number of falling edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            prev <= 1'b0;
            low_len <= 0;
            falls <= 0;
        end else begin
            prev <= reset_in_n;
            if (reset_in_n !== 1'b1) begin
                cnt <= cnt + 1;
            end
            if (prev === 1'b1 && reset_in_n !== 1'b1) begin
                falls <= falls + 1;
                cnt <= 1;
            end
            if (prev !== 1'b1 && reset_in_n === 1'b1) begin
                low_len <= cnt;
                cnt <= 0;
            end
        end
    end
endmodule // mcu_model

// ==== bench/tb.sv ====
// self-checking testbench of the reset sequencer
`timescale 1ns/100ps
module tb;
    logic clk;
    logic nrst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic supply_low;
    logic watchdog_fail_count;
    logic [7:0] rdata;
    logic reset_out_n;
    logic [1:0] uv_thresh_sel;
    logic soft_reset_pulse;
    logic irq;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int low_len;
    int falls;
    int n;
    int f;
    logic [7:0] d;

    reset_sequencer #(.LONG_DELAY_CYC(40), .SHORT_DELAY_CYC(20)) dut (
        .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SUPPLY_LOW(supply_low),
        .WATCHDOG_FAIL_COUNT(watchdog_fail_count), .RESET_OUT_N(reset_out_n),
        .UV_THRESH_SEL(uv_thresh_sel),
        .SOFT_RESET_PULSE(soft_reset_pulse), .IRQ(irq)
    );

    mcu_model host (
        .clk(clk), .nrst(nrst), .reset_in_n(reset_out_n),
        .low_len(low_len), .falls(falls)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic wait_rst(input logic v, input int lim, output int k);
        k = 0;
        while (reset_out_n !== v && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic pulse_wd();
        @(posedge clk);
        watchdog_fail_count <= 1'b1;
        @(posedge clk);
        watchdog_fail_count <= 1'b0;
    endtask

    task automatic t_power();
        chk("reset_out_n at start", reset_out_n, 1'b0);
        chk("thr default", uv_thresh_sel, 2'h0);
        wait_rst(1'b1, 100, n);
        chk("power-up delay", n >= 40 && n <= 50, 1'b1);
        rreg(4'h0, d);
        chk("ctrl default", d, 8'h00);
        rreg(4'h2, d);
        chk("mode normal", d[4:2], 3'h1);
        $display("test power done");
    endtask

    task automatic t_uv();
        @(posedge clk);
        supply_low <= 1'b1;
        repeat (990) @(posedge clk);
        #1;
        chk("reset_out_n in filter", reset_out_n, 1'b1);
        wait_rst(1'b0, 30, n);
        chk("reset_out_n after filter", reset_out_n, 1'b0);
        repeat (200) @(posedge clk);
        #1;
        chk("reset_out_n while cause", reset_out_n, 1'b0);
        @(posedge clk);
        supply_low <= 1'b0;
        wait_rst(1'b1, 60, n);
        chk("long release", n >= 40 && n <= 50, 1'b1);
        rreg(4'h3, d);
        chk("irq stat rst", d[0], 1'b1);
        chk("irq masked", irq, 1'b0);
        wreg(4'h4, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq unmasked", irq, 1'b1);
        wreg(4'h3, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", irq, 1'b0);
        rreg(4'hF, d);
        chk("unmapped read", d, 8'h00);
        $display("test undervoltage done");
    endtask

    task automatic t_wd();
        wreg(4'h0, 8'h01);
        pulse_wd();
        repeat (995) @(posedge clk);
        #1;
        chk("wd filter", reset_out_n, 1'b1);
        wait_rst(1'b0, 20, n);
        chk("wd reset", reset_out_n, 1'b0);
        rreg(4'h2, d);
        chk("wd restart mode", d[4:2], 3'h3);
        chk("wd count", d[1:0], 2'h1);
        wreg(4'h1, 8'h03);
        #1;
        chk("soft in restart", soft_reset_pulse, 1'b0);
        repeat (10) @(posedge clk);
        pulse_wd();
        wait_rst(1'b1, 80, n);
        @(posedge clk);
        #1;
        chk("short restarted", low_len >= 34 && low_len <= 42, 1'b1);
        rreg(4'h2, d);
        chk("wd count two", d[1:0], 2'h2);
        $display("test watchdog done");
    endtask

    task automatic t_soft0();
        wreg(4'h0, 8'h0C);
        #1;
        chk("thr select", uv_thresh_sel, 2'h3);
        wreg(4'h1, 8'h03);
        #1;
        chk("soft pulse", soft_reset_pulse, 1'b1);
        chk("soft reset_out_n low", reset_out_n, 1'b0);
        chk("thr defaulted", uv_thresh_sel, 2'h0);
        wait_rst(1'b1, 60, n);
        @(posedge clk);
        #1;
        chk("soft long delay", low_len >= 40 && low_len <= 42, 1'b1);
        rreg(4'h0, d);
        chk("ctrl after soft", d, 8'h00);
        $display("test soft reset pulse done");
    endtask

    task automatic t_soft1();
        f = falls;
        wreg(4'h0, 8'h02);
        wreg(4'h1, 8'h01);
        wreg(4'h1, 8'h03);
        #1;
        chk("soft in stop", soft_reset_pulse, 1'b1);
        repeat (60) @(posedge clk);
        #1;
        chk("no reset pulse", falls, f);
        chk("reset_out_n kept", reset_out_n, 1'b1);
        rreg(4'h0, d);
        chk("ctrl reinit", d, 8'h00);
        wreg(4'h0, 8'h10);
        pulse_wd();
        rreg(4'h2, d);
        chk("wd failsafe mode", d[4:2], 3'h4);
        chk("wd count after soft", d[1:0], 2'h1);
        wreg(4'h1, 8'h00);
        rreg(4'h2, d);
        chk("failsafe left by normal", d[4:2], 3'h1);
        $display("test soft reset keep done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        supply_low = 1'b0;
        watchdog_fail_count = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        t_power();
        t_uv();
        t_wd();
        t_soft0();
        t_soft1();
        final_report();
    end
endmodule // tb
